// ===== hwd_watchdog_flags.sv
// host watchdog, sticky event flags and the two open-drain status pins
// assumes the serial engine gives same-clock register strobes and a
// transaction-start pulse; pins and supply comparator are asynchronous
//
// How it works
// - watchdog runs only in modes picked by the two-bit enable field
// - each qualifying host activity restarts the count; host feeds in time
// - feed source field: serial only, kick pin only, either for 2 and 3
// - timeout with no feed sets event bit 4 of event register 7
// - timeout period field picks 25 s or 50 s
// - reload enable turns outputs off for about 20 ms right after a timeout
// - afterwards reload defaults, which switch the watchdog off; keep button low four bits
// - host reset enable pulses the host reset output on timeout
// - thirty-six event bits held in event registers 3 to 7
// - event bits latch high and stay until cleared
// - first read reports an event, second read clears it
// - pin mode bit 4 picks supply status or button copy
// - button copy follows the button about 1.5 ms later
// - supply mode pulls the power pin low only while supply valid
// - power pin is never driven high, only released
// - each event gives a 128 us pulse on the interrupt pin
// - pin mode bit 0 also shows charging on the interrupt pin
// - pulse low normally; low while charging, pulses then go high
// - mask bits stop pulses but not the event bits
// - one pulse per event until its bit is read-cleared
`timescale 1ns/1ps
module hwd_watchdog_flags #(
    parameter int TICK_CYC  = hwd_pkg::TICK_CYCLES,
    parameter int IRQ_TK    = hwd_pkg::IRQ_TICKS,
    parameter int PB_TK     = hwd_pkg::PB_TICKS,
    parameter int OFF_TK    = hwd_pkg::OFF_TICKS,
    parameter int HRST_TK   = hwd_pkg::HRST_TICKS,
    parameter int WD_SH_TK  = hwd_pkg::WD_SHORT_TICKS,
    parameter int WD_LG_TK  = hwd_pkg::WD_LONG_TICKS
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    // register port
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic [7:0]            i_reg_wdata,
    output logic      [7:0]            o_reg_rdata,
    // host activity
    input  wire logic                  i_i2c_start,
    input  wire logic                  i_host_kick_pin,
    // chip status
    input  wire hwd_pkg::hwd_op_mode_t i_op_mode,
    input  wire logic                  i_charging,
    input  wire logic [39:0]           i_events,
    input  wire logic                  i_input_supply_valid,
    input  wire logic                  i_pushbutton_input_n,
    // interrupt pin
    output logic                       o_irq_o,
    output logic                       o_irq_oe,
    // power fault pin
    output logic                       o_pwr_fault_o,
    output logic                       o_pwr_fault_oe,
    // host reset pin
    output logic                       o_host_reset_o,
    output logic                       o_host_reset_oe,
    // power control
    output logic                       o_outputs_off
);
    import hwd_pkg::*;

    function automatic logic wd_mode_on(input logic [1:0] en,
                                        input hwd_op_mode_t md);
        logic on;
        on = 1'b0;
        case (md)
            HWD_MODE_CHARGE:     on = (en != 2'h0);
            HWD_MODE_ACTIVE_BAT: on = (en >= 2'h2);
            HWD_MODE_HIZ:        on = (en == 2'h3);
            default:             on = 1'b0;
        endcase
        return on;
    endfunction

    function automatic logic [39:0] evt_sel(input logic [7:0] addr);
        logic [39:0] s;
        s = '0;
        for (int i = 0; i < EVT_REGS; i++) begin
            if (addr == ADDR_EVT_FIRST + 8'(i)) begin
                s[i*8 +: 8] = 8'hFF;
            end
        end
        return s;
    endfunction

    // registers
    logic [7:0]  mask_r [EVT_REGS];
    logic [7:0]  btn_r;
    logic [7:0]  pincfg_r;
    logic [7:0]  wdctl_r;
    logic [39:0] evt_r;
    logic [39:0] rep_r;
    logic [39:0] sig_r;
    logic [39:0] src_prev_r;

    // synchronisers: kick, supply, button
    logic [2:0]  sync1_r;
    logic [2:0]  sync2_r;
    logic        kick_prev_r;
    logic        pb_dly_r;

    // divider
    logic [15:0] tick_cnt_r;
    logic        tick_r;

    // timer handshakes
    logic        wd_busy;
    logic        wd_to;
    logic        irq_busy;
    logic        off_busy;
    logic        off_done;
    logic        hrst_busy;
    logic        pb_busy;
    logic        pb_done;

    logic        kick_s;
    logic        supply_s;
    logic        pb_s;
    logic        wd_on;
    logic        feed;
    logic        kick_edge;
    logic        irq_mode;
    logic        pwr_mode;
    logic        reload_en;
    logic        rout_en;
    logic [1:0]  feed_sel;
    logic [TIMER_W-1:0] wd_limit;
    logic [39:0] src_now;
    logic [39:0] rise;
    logic [39:0] rd_sel;
    logic [39:0] mask_all;
    logic [39:0] pending;
    logic        irq_start;
    logic [39:0] evt_nxt;
    logic [39:0] rep_nxt;
    logic [7:0]  rd_nxt;
    logic        irq_low_nxt;

    assign kick_s    = sync2_r[0];
    assign supply_s  = sync2_r[1];
    assign pb_s      = sync2_r[2];
    assign irq_mode  = pincfg_r[PIN_IRQ_MODE_BIT];
    assign pwr_mode  = pincfg_r[PIN_PWR_MODE_BIT];
    assign reload_en = wdctl_r[WD_RELOAD_BIT];
    assign rout_en   = wdctl_r[WD_ROUT_BIT];
    assign feed_sel  = wdctl_r[WD_CLR_LSB +: 2];

    // slow tick
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    // pin synchronisers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sync1_r     <= 3'h5;
            sync2_r     <= 3'h5;
            kick_prev_r <= 1'b1;
        end else begin
            sync1_r     <= {i_pushbutton_input_n, i_input_supply_valid,
                            i_host_kick_pin};
            sync2_r     <= sync1_r;
            kick_prev_r <= kick_s;
        end
    end

    // watchdog
    assign kick_edge = kick_s ^ kick_prev_r;
    assign wd_on     = wd_mode_on(wdctl_r[WATCHDOG_MODE_ENABLE_LSB +: 2], i_op_mode)
                       && !off_busy;
    always_comb begin
        case (feed_sel)
            FEED_I2C:  feed = i_i2c_start;
            FEED_KICK: feed = kick_edge;
            default:   feed = i_i2c_start || kick_edge;
        endcase
    end
    assign wd_limit = (wdctl_r[WD_PER_LSB +: 2] == 2'h0)
                      ? TIMER_W'(WD_SH_TK) : TIMER_W'(WD_LG_TK);

    hwd_timer #(.W(TIMER_W)) u_wd_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick_r),
        .i_start   (wd_on && (feed || !wd_busy)),
        .i_stop    (!wd_on),
        .i_limit   (wd_limit),
        .o_busy    (wd_busy),
        .o_done    (wd_to)
    );

    // output power-down after a timeout
    hwd_timer #(.W(TIMER_W)) u_off_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick_r),
        .i_start   (wd_to && reload_en),
        .i_stop    (1'b0),
        .i_limit   (TIMER_W'(OFF_TK)),
        .o_busy    (off_busy),
        .o_done    (off_done)
    );

    // host reset pulse after a timeout
    hwd_timer #(.W(TIMER_W)) u_hrst_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick_r),
        .i_start   (wd_to && rout_en),
        .i_stop    (1'b0),
        .i_limit   (TIMER_W'(HRST_TK)),
        .o_busy    (hrst_busy),
        .o_done    ()
    );

    // button copy delay
    hwd_timer #(.W(TIMER_W)) u_pb_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick_r),
        .i_start   ((pb_s != pb_dly_r) && !pb_busy),
        .i_stop    (pb_s == pb_dly_r),
        .i_limit   (TIMER_W'(PB_TK)),
        .o_busy    (pb_busy),
        .o_done    (pb_done)
    );

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pb_dly_r <= 1'b1;
        end else if (pb_done) begin
            pb_dly_r <= pb_s;
        end
    end

    // event flags
    always_comb begin
        src_now = i_events & EVT_USED;
        src_now[EVT_WD_IDX] = wd_to;
        rise     = src_now & ~src_prev_r;
        rd_sel   = i_reg_rd ? evt_sel(i_reg_addr) : '0;
        evt_nxt  = (evt_r & ~(rd_sel & rep_r)) | rise;
        rep_nxt  = (rep_r ^ (rd_sel & evt_r)) & ~rise & evt_nxt;
        for (int i = 0; i < EVT_REGS; i++) begin
            mask_all[i*8 +: 8] = mask_r[i];
        end
        pending   = evt_r & ~sig_r & ~mask_all;
        irq_start = (pending != '0) && !irq_busy;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            evt_r      <= '0;
            rep_r      <= '0;
            sig_r      <= '0;
            src_prev_r <= '0;
        end else begin
            evt_r      <= evt_nxt;
            rep_r      <= rep_nxt;
            sig_r      <= (sig_r | (irq_start ? pending : '0))
                          & evt_nxt;
            src_prev_r <= src_now;
        end
    end

    hwd_timer #(.W(TIMER_W)) u_irq_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick_r),
        .i_start   (irq_start),
        .i_stop    (1'b0),
        .i_limit   (TIMER_W'(IRQ_TK)),
        .o_busy    (irq_busy),
        .o_done    ()
    );

    // register writes and factory reload
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < EVT_REGS; i++) begin
                mask_r[i] <= MASK_RST;
            end
            btn_r    <= BTN_RST;
            pincfg_r <= PINCFG_RST;
            wdctl_r  <= WDCTL_RST;
        end else if (off_done) begin
            for (int i = 0; i < EVT_REGS; i++) begin
                mask_r[i] <= MASK_RST;
            end
            btn_r    <= (BTN_RST & ~BTN_KEEP_MASK)
                        | (btn_r & BTN_KEEP_MASK);
            pincfg_r <= PINCFG_RST;
            wdctl_r  <= WDCTL_RST;
        end else if (i_reg_wr) begin
            for (int i = 0; i < EVT_REGS; i++) begin
                if (i_reg_addr == ADDR_MASK_FIRST + 8'(i)) begin
                    mask_r[i] <= i_reg_wdata;
                end
            end
            if (i_reg_addr == ADDR_BUTTON) begin
                btn_r <= i_reg_wdata;
            end
            if (i_reg_addr == ADDR_PINCFG) begin
                pincfg_r <= i_reg_wdata;
            end
            if (i_reg_addr == ADDR_WDCTL) begin
                wdctl_r <= i_reg_wdata;
            end
        end
    end

    // read data
    always_comb begin
        rd_nxt = 8'h00;
        for (int i = 0; i < EVT_REGS; i++) begin
            if (i_reg_addr == ADDR_EVT_FIRST + 8'(i)) begin
                rd_nxt = evt_r[i*8 +: 8];
            end
            if (i_reg_addr == ADDR_MASK_FIRST + 8'(i)) begin
                rd_nxt = mask_r[i];
            end
        end
        if (i_reg_addr == ADDR_BUTTON) begin
            rd_nxt = btn_r;
        end
        if (i_reg_addr == ADDR_PINCFG) begin
            rd_nxt = pincfg_r;
        end
        if (i_reg_addr == ADDR_WDCTL) begin
            rd_nxt = wdctl_r;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_nxt;
        end
    end

    // pins
    assign irq_low_nxt = (irq_mode && i_charging) ? !irq_busy
                                                   : irq_busy;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_irq_o         <= 1'b0;
            o_irq_oe        <= 1'b0;
            o_pwr_fault_o   <= 1'b0;
            o_pwr_fault_oe  <= 1'b0;
            o_host_reset_o  <= 1'b0;
            o_host_reset_oe <= 1'b0;
            o_outputs_off   <= 1'b0;
        end else begin
            o_irq_o         <= 1'b0;
            o_irq_oe        <= irq_low_nxt;
            o_pwr_fault_o   <= 1'b0;
            o_pwr_fault_oe  <= pwr_mode ? !pb_dly_r : supply_s;
            o_host_reset_o  <= 1'b0;
            o_host_reset_oe <= hrst_busy;
            o_outputs_off   <= off_busy;
        end
    end

    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_wd_reload;
        wd_to && reload_en;
    endsequence

    sequence s_wd_rout;
        wd_to && rout_en;
    endsequence

    sequence s_first_read;
        i_reg_rd && (i_reg_addr == ADDR_EVT_LAST) && evt_r[EVT_WD_IDX]
            && !rep_r[EVT_WD_IDX] && !rise[EVT_WD_IDX];
    endsequence

    sequence s_second_read;
        i_reg_rd && (i_reg_addr == ADDR_EVT_LAST) && !rise[EVT_WD_IDX];
    endsequence

    AST_PWR_NEVER_HIGH: assert property (!o_pwr_fault_o)
        else $error("power pin driven high");

    AST_PWR_SUPPLY: assert property (
        (!pwr_mode && $stable(pwr_mode)) |=> o_pwr_fault_oe == $past(supply_s))
        else $error("power pin does not follow supply status");

    AST_WD_EVENT: assert property (wd_to |=> evt_r[EVT_WD_IDX])
        else $error("timeout did not set the event bit");

    AST_EVT_STICKY: assert property (
        (evt_r[EVT_WD_IDX] && !(i_reg_rd && i_reg_addr == ADDR_EVT_LAST))
        |=> evt_r[EVT_WD_IDX])
        else $error("event bit dropped without a read");

    AST_READ_TWICE: assert property (
        s_first_read ##1 (!i_reg_rd && !rise[EVT_WD_IDX]) ##1 s_second_read
        |=> !evt_r[EVT_WD_IDX])
        else $error("two reads did not clear the event");

    AST_FIRST_READ_KEEPS: assert property (s_first_read |=>
        evt_r[EVT_WD_IDX] && rep_r[EVT_WD_IDX])
        else $error("first read cleared the event");

    AST_IRQ_ONCE: assert property (
        $rose(irq_busy) |-> ($past(pending) != '0))
        else $error("pulse without a pending unmasked event");

    AST_WD_OFF: assert property (!wd_on |=> !wd_busy)
        else $error("watchdog counts while disabled");

    AST_RELOAD_OFF: assert property (
        s_wd_reload |=> ##1 o_outputs_off[*3])
        else $error("outputs not turned off after timeout");

    AST_HOST_RESET: assert property (
        s_wd_rout |=> ##1 o_host_reset_oe)
        else $error("host reset not pulsed on timeout");

    AST_IRQ_CHARGE: assert property (
        (irq_mode && i_charging && !irq_busy) |=> o_irq_oe)
        else $error("interrupt pin not low while charging");
endmodule

// ===== hwd_pkg.sv
// constants, field layout and enumerations of the host watchdog block
// assumes a 250 MHz core clock and an 8-bit internal register port
package hwd_pkg;

    // register offsets
    localparam logic [7:0] ADDR_EVT_FIRST  = 8'h03;
    localparam logic [7:0] ADDR_EVT_LAST   = 8'h07;
    localparam logic [7:0] ADDR_MASK_FIRST = 8'h08;
    localparam logic [7:0] ADDR_MASK_LAST  = 8'h0C;
    localparam logic [7:0] ADDR_BUTTON     = 8'h10;
    localparam logic [7:0] ADDR_PINCFG     = 8'h11;
    localparam logic [7:0] ADDR_WDCTL      = 8'h14;

    // event vector layout
    localparam int          EVT_REGS   = 5;
    localparam int          EVT_BITS   = EVT_REGS * 8;
    localparam logic [39:0] EVT_USED   = 40'h17_FFFF_FFFF;
    localparam int          EVT_WD_IDX = 36;

    // watchdog control fields
    localparam int WATCHDOG_MODE_ENABLE_LSB     = 0;
    localparam int WD_CLR_LSB    = 2;
    localparam int WD_PER_LSB    = 4;
    localparam int WD_ROUT_BIT   = 6;
    localparam int WD_RELOAD_BIT = 7;

    // pin configuration fields
    localparam int PIN_IRQ_MODE_BIT = 0;
    localparam int PIN_PWR_MODE_BIT = 4;

    // button register bits kept across a reload
    localparam logic [7:0] BTN_KEEP_MASK = 8'h0F;

    // factory default values
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] BTN_RST    = 8'h00;
    localparam logic [7:0] PINCFG_RST = 8'h00;
    localparam logic [7:0] WDCTL_RST  = 8'h00;

    // feed source encodings
    localparam logic [1:0] FEED_I2C  = 2'h0;
    localparam logic [1:0] FEED_KICK = 2'h1;

    // operating modes reported by the power controller
    typedef enum logic [1:0] {
        HWD_MODE_CHARGE,
        HWD_MODE_ACTIVE_BAT,
        HWD_MODE_HIZ,
        HWD_MODE_SHIP
    } hwd_op_mode_t;

    // timing, in printed units, then in slow ticks
    localparam int  CLK_MHZ      = 250;
    localparam int  TICK_US      = 1;
    localparam int  TICK_CYCLES  = CLK_MHZ * TICK_US;
    localparam int  IRQ_PULSE_US = 128;
    localparam int  IRQ_TICKS    = IRQ_PULSE_US / TICK_US;
    localparam real PB_DELAY_MS  = 1.5;
    localparam int  PB_TICKS     = $rtoi(PB_DELAY_MS * 1000.0) / TICK_US;
    localparam int  OFF_MS       = 20;
    localparam int  OFF_TICKS    = OFF_MS * 1000 / TICK_US;
    localparam int  HRST_MS      = 400;
    localparam int  HRST_TICKS   = HRST_MS * 1000 / TICK_US;
    localparam int  WD_SHORT_S   = 25;
    localparam int  WD_LONG_S    = 50;
    localparam int  WD_SHORT_TICKS = WD_SHORT_S * 1000000 / TICK_US;
    localparam int  WD_LONG_TICKS  = WD_LONG_S * 1000000 / TICK_US;
    localparam int  TIMER_W      = 26;

endpackage

// ===== hwd_timer.sv
// one-shot tick counter: runs for i_limit + 1 ticks after a start
// assumes i_tick is a one-cycle enable from the block's divider
`timescale 1ns/1ps
module hwd_timer #(
    parameter int W = 26
) (
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    // control
    input  wire logic         i_tick,
    input  wire logic         i_start,
    input  wire logic         i_stop,
    input  wire logic [W-1:0] i_limit,
    // status
    output logic              o_busy,
    output logic              o_done
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_r  <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                cnt_r  <= '0;
                o_busy <= 1'b1;
            end else if (i_stop) begin
                o_busy <= 1'b0;
            end else if (o_busy && i_tick) begin
                if (cnt_r >= i_limit) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + W'(1);
                end
            end
        end
    end
endmodule

// ===== hwd_host_model.sv
// host model: feeds the watchdog at a fixed gap while enabled
// assumes the bench picks the feed source and switches feeding
`timescale 1ns/1ps
module hwd_host_model #(
    parameter int GAP = 60
) (
    // clock
    input  wire logic i_ref_clk,
    // control from the bench
    input  wire logic i_feed_en,
    input  wire logic i_use_kick,
    // host activity
    output logic      o_kick,
    output logic      o_i2c_start
);
    int cnt = 0;

    initial begin
        o_kick = 1'b1;
        o_i2c_start = 1'b0;
        forever begin
            @(posedge i_ref_clk);
            #1;
            o_i2c_start = 1'b0;
            cnt = i_feed_en ? cnt + 1 : 0;
            if (cnt == GAP) begin
                cnt = 0;
                if (i_use_kick)
                    o_kick = ~o_kick;
                else
                    o_i2c_start = 1'b1;
            end
        end
    end
endmodule

// ===== hwd_watchdog_flags_test.sv
// self-checking bench for the host watchdog and event flags
// assumes shortened tick counts and the host model beside it
`timescale 1ns/1ps
module hwd_watchdog_flags_test;
    import hwd_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         wr = 1'b0;
    logic         rd = 1'b0;
    logic [7:0]   addr = 8'h00;
    logic [7:0]   wdat = 8'h00;
    logic [7:0]   rdat;
    logic [39:0]  ev = '0;
    hwd_op_mode_t mode = HWD_MODE_CHARGE;
    logic         chg = 1'b0;
    logic         sup = 1'b1;
    logic         btn_n = 1'b1;
    logic         feed = 1'b0;
    logic         use_kick = 1'b0;
    logic         kick, i2c, irq_o, irq_oe, pf_o, pf_oe, hr_o, hr_oe, off;
    logic [15:0]  q[$];
    logic [15:0]  e;
    logic         pend = 1'b0;
    int           n_mismatch = 0;
    int           n_compared = 0;

    initial forever #2 clk = ~clk;

    hwd_watchdog_flags #(.TICK_CYC(4), .IRQ_TK(4), .OFF_TK(10),
        .WD_SH_TK(50), .WD_LG_TK(100)) DUT (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdat),
        .i_i2c_start(i2c), .i_host_kick_pin(kick), .i_op_mode(mode),
        .i_charging(chg), .i_events(ev), .i_input_supply_valid(sup),
        .i_pushbutton_input_n(btn_n), .o_irq_o(irq_o), .o_irq_oe(irq_oe),
        .o_pwr_fault_o(pf_o), .o_pwr_fault_oe(pf_oe), .o_host_reset_o(hr_o),
        .o_host_reset_oe(hr_oe), .o_outputs_off(off));

    hwd_host_model host (.i_ref_clk(clk), .i_feed_en(feed),
        .i_use_kick(use_kick), .o_kick(kick), .o_i2c_start(i2c));

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read data is one cycle after the strobe; open-drain data never high
    always @(negedge clk) begin
        if (pend) begin
            e = q.pop_front();
            chk(rdat & e[15:8], e[7:0]);
        end
        pend = rd;
        chk({5'h00, pf_o, irq_o, hr_o}, 8'h00);
    end

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        {wr, addr, wdat} = {1'b1, a, d};
        cyc(1);
        wr = 1'b0;
    endtask

    task automatic rd8(input logic [7:0] a, input logic [7:0] x,
                       input logic [7:0] m = 8'hff);
        q.push_back({m, x & m});
        cyc(1);
        {rd, addr} = {1'b1, a};
        cyc(1);
        rd = 1'b0;
    endtask

    task automatic pulse_ev(input int k);
        cyc(1);
        ev[k] = 1'b1;
        cyc(1);
        ev[k] = 1'b0;
    endtask

    // width of the next interrupt pulse at oe level lv
    task automatic pw(input logic lv);
        int t;
        for (t = 0; t < 100 && irq_oe !== lv; t++) cyc(1);
        for (t = 0; t < 100 && irq_oe === lv; t++) cyc(1);
        chk(8'(t >= 16 && t <= 20), 8'h01);
    endtask

    task automatic quiet(input logic lv);
        repeat (40) begin
            cyc(1);
            chk({7'h00, irq_oe}, {7'h00, lv});
        end
    endtask

    task automatic clr(input int k);
        rd8(8'(3 + k / 8), 8'h00, 8'h00);
        rd8(8'(3 + k / 8), 8'h00, 8'h00);
    endtask

    task automatic wd(input logic [1:0] en, input logic [1:0] sel,
                      input int md, input logic fd, input logic src,
                      input logic per, input int c);
        logic to;
        to = (en > md) && !(fd && (sel[1] || sel == {1'b0, src}))
            && c > (per ? 400 : 200);
        mode = hwd_op_mode_t'(md);
        {feed, use_kick} = {fd, src};
        wr8(ADDR_WDCTL, {3'b000, per, sel, en});
        cyc(c);
        feed = 1'b0;
        wr8(ADDR_WDCTL, 8'h00);
        rd8(ADDR_EVT_LAST, {3'b000, to, 4'h0}, 8'h10);
        clr(EVT_WD_IDX);
    endtask

    initial begin
        int k, j;
        logic [7:0] v;
        void'($urandom(82473));
        cyc(20);
        rst_n = 1'b1;
        for (k = 3; k <= 'h14; k++) rd8(8'(k), 8'h00);
        rd8(8'h20, 8'h00);
        wr8(ADDR_EVT_LAST, 8'hff);
        rd8(ADDR_EVT_LAST, 8'h00);
        v = 8'($urandom);
        wr8(ADDR_BUTTON, v);
        rd8(ADDR_BUTTON, v);
        wr8(ADDR_WDCTL, v & 8'hfc);
        rd8(ADDR_WDCTL, v & 8'hfc);
        wr8(ADDR_WDCTL, 8'h00);
        k = $urandom % 35;
        pulse_ev(k);
        pw(1'b1);
        pulse_ev(k);
        quiet(1'b0);
        rd8(8'(3 + k / 8), 8'h01 << (k % 8));
        rd8(8'(3 + k / 8), 8'h00, 8'h00);
        rd8(8'(3 + k / 8), 8'h00);
        j = (k + 1 + $urandom % 34) % 35;
        wr8(8'(8 + j / 8), 8'h01 << (j % 8));
        pulse_ev(j);
        quiet(1'b0);
        rd8(8'(3 + j / 8), 8'h01 << (j % 8));
        wr8(8'(8 + j / 8), 8'h00);
        pw(1'b1);
        clr(j);
        wr8(ADDR_PINCFG, 8'h01);
        chg = 1'b1;
        cyc(4);
        chk({7'h00, irq_oe}, 8'h01);
        pulse_ev(k);
        pw(1'b0);
        clr(k);
        chg = 1'b0;
        wr8(ADDR_PINCFG, 8'h00);
        cyc(4);
        chk({7'h00, pf_oe}, 8'h01);
        sup = 1'b0;
        cyc(6);
        chk({7'h00, pf_oe}, 8'h00);
        wr8(ADDR_PINCFG, 8'h10);
        btn_n = 1'b0;
        cyc(20);
        chk({7'h00, pf_oe}, 8'h00);
        cyc(4 * PB_TICKS);
        chk({7'h00, pf_oe}, 8'h01);
        btn_n = 1'b1;
        sup = 1'b1;
        wr8(ADDR_PINCFG, 8'h00);
        for (k = 0; k < 16; k++)
            wd(k[1:0], k[3:2], $urandom % 3, 1'($urandom), 1'($urandom),
               1'b0, 260);
        wd(2'h3, 2'h0, 2, 1'b0, 1'b0, 1'b1, 260);
        wd(2'h3, 2'h0, 2, 1'b0, 1'b0, 1'b1, 460);
        wr8(ADDR_BUTTON, 8'hff);
        mode = HWD_MODE_CHARGE;
        wr8(ADDR_WDCTL, 8'hc1);
        for (k = 0; k < 300 && off !== 1'b1; k++) cyc(1);
        chk({6'h00, off, hr_oe}, 8'h03);
        for (k = 0; k < 60 && off === 1'b1; k++) cyc(1);
        chk({7'h00, off}, 8'h00);
        rd8(ADDR_BUTTON, 8'h0f);
        rd8(ADDR_WDCTL, 8'h00);
        cyc(4);
        finish_test;
    end

    initial begin
        #100us;
        n_mismatch++;
        finish_test;
    end
endmodule
